// *** core/bma_map.svh ***
// Address map constants for the banked memory address decoder.
// Assumes inclusion by every design file that needs offsets or reset values.
`ifndef BMA_MAP_SVH
`define BMA_MAP_SVH

// Program side widths and vectors
`define BMA_PC_W            13
`define BMA_PMEM_AW         11
`define BMA_JUMP_LIT_W      11
`define BMA_PROGRAM_COUNTER_UPPER_LATCH_W        5
`define BMA_RESET_VECTOR    13'h0000
`define BMA_IRQ_VECTOR      13'h0004

// Data side widths
`define BMA_OFS_W           7
`define BMA_RAM_DEPTH       128
`define BMA_FLAGS_W         3

// Core register offsets, identical in every bank
`define BMA_OFS_INDIRECT    7'h00
`define BMA_OFS_PCL         7'h02
`define BMA_OFS_STATUS      7'h03
`define BMA_OFS_FSR         7'h04
`define BMA_OFS_PROGRAM_COUNTER_UPPER_LATCH      7'h0a

// Static RAM windows inside a bank
`define BMA_GPR_BASE        7'h20
`define BMA_BANK1_GPR_END   7'h40
`define BMA_SHARED_BASE     7'h70
`define BMA_BANK1_IDX_ADD   7'h40

// Status register layout
`define BMA_ST_IRP          7
`define BMA_ST_RP1          6
`define BMA_ST_RP0          5
`define BMA_ST_WR_MASK      8'he7

// Reset values
`define BMA_STATUS_RST      8'h18
`define BMA_FSR_RST         8'h00
`define BMA_PROGRAM_COUNTER_UPPER_LATCH_RST      5'h00
`define BMA_RDATA_RST       8'h00

`endif

// *** core/bma_pkg.sv ***
// Types shared by the banked memory address decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package bma_pkg;
    typedef logic [1:0] bma_bank_t;     // Bank number 0..3
    typedef logic [6:0] bma_ofs_t;      // Offset inside a bank
    // Kind of target an access lands on; one-hot codes
    typedef enum logic [3:0] {
        BMA_RG_NONE = 4'h1,
        BMA_RG_CORE = 4'h2,
        BMA_RG_RAM  = 4'h4,
        BMA_RG_INDF = 4'h8
    } bma_region_t;
endpackage

// *** core/bma_pc_gen.sv ***
// Program counter and program memory address for the fetch bus.
// Assumes the fetch strobes are synchronous to clk_sys_i and one-cycle wide.
`timescale 1ns/10ps
`default_nettype none
`include "bma_map.svh"

module bma_pc_gen (
    input  wire logic                        clk_sys_i,
    input  wire logic                        nrst_i,
    input  wire logic                        adv_i,
    input  wire logic                        jump_i,
    input  wire logic [`BMA_JUMP_LIT_W-1:0]  jump_lit_i,
    input  wire logic                        irq_i,
    input  wire logic                        pcl_wr_i,
    input  wire logic [7:0]                  pcl_data_i,
    input  wire logic [`BMA_PROGRAM_COUNTER_UPPER_LATCH_W-1:0]    latch_i,
    output logic      [`BMA_PC_W-1:0]        pc_o,
    output logic      [`BMA_PMEM_AW-1:0]     prog_addr_o
);
    import bma_pkg::*;

    logic [`BMA_PC_W-1:0] pc_r;     // Full program counter
    logic [`BMA_PC_W-1:0] pc_nxt;   // Next counter value

    // Next value; interrupt beats a computed write, which beats a jump
    always_comb begin
        pc_nxt = pc_r;
        if (irq_i) begin
            pc_nxt = `BMA_IRQ_VECTOR;
        end else if (pcl_wr_i) begin
            pc_nxt = {latch_i, pcl_data_i};
        end else if (jump_i) begin
            pc_nxt = {latch_i[4:3], jump_lit_i};
        end else if (adv_i) begin
            // Wraps at 13 bits by width alone
            pc_nxt = pc_r + 13'h0001;
        end
    end

    // Counter and the fetch address, both registered
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            pc_r        <= `BMA_RESET_VECTOR;
            // Vector cut to the implemented fetch width on purpose
            prog_addr_o <= `BMA_PMEM_AW'(`BMA_RESET_VECTOR);
        end else begin
            pc_r        <= pc_nxt;
            // Upper two bits dropped so fetches above 2K fold back
            prog_addr_o <= pc_nxt[`BMA_PMEM_AW-1:0];
        end
    end

    assign pc_o = pc_r;

    chk_reset_fetch_zero: assert property (@(posedge clk_sys_i)
        !nrst_i |=> (pc_o == 13'h0000 && prog_addr_o == 11'h000))
        else $error("fetch does not restart at zero after reset");

    chk_irq_vector_four: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        irq_i |=> (pc_o == 13'h0004))
        else $error("interrupt did not redirect fetch to four");

    chk_pc_increment: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (adv_i && !irq_i && !pcl_wr_i && !jump_i) |=> (pc_o == $past(pc_o) + 13'h0001))
        else $error("program counter did not step by one");

    chk_fetch_wrap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        pc_o[12:11] != 2'b00 |-> prog_addr_o == pc_o[10:0])
        else $error("high fetch address did not wrap into 2K");

    cov_irq_taken: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        irq_i ##1 adv_i);
endmodule

`default_nettype wire

// *** core/bma_data_decode.sv ***
// Combinational decode of one bank/offset pair into a target kind and RAM slot.
// Assumes the caller has already resolved direct versus indirect addressing.
`timescale 1ns/10ps
`default_nettype none
`include "bma_map.svh"

module bma_data_decode (
    input  wire bma_pkg::bma_bank_t    bank_i,
    input  wire bma_pkg::bma_ofs_t     ofs_i,
    output bma_pkg::bma_region_t       region_o,
    output logic [6:0]                 ram_idx_o
);
    import bma_pkg::*;

    // Maps to {hit, index}; banks 2 and 3 fold onto 0 and 1
    function automatic logic [7:0] ram_slot(input bma_bank_t bank, input bma_ofs_t ofs);
        logic [7:0] res;
        res = 8'h00;
        if (ofs >= `BMA_SHARED_BASE) begin
            res = {1'b1, ofs - `BMA_GPR_BASE};
        end else if (ofs >= `BMA_GPR_BASE) begin
            if (!bank[0]) begin
                res = {1'b1, ofs - `BMA_GPR_BASE};
            end else if (ofs < `BMA_BANK1_GPR_END) begin
                res = {1'b1, ofs + `BMA_BANK1_IDX_ADD};
            end
        end
        return res;
    endfunction

    logic [7:0] slot;   // Hit flag and index

    // Low offsets are registers, upper offsets static RAM save the odd-bank gap below the shared window
    always_comb begin
        slot      = ram_slot(bank_i, ofs_i);
        ram_idx_o = slot[6:0];
        case (ofs_i)
            `BMA_OFS_INDIRECT: region_o = BMA_RG_INDF;
            // Same physical registers from every bank
            `BMA_OFS_PCL,
            `BMA_OFS_STATUS,
            `BMA_OFS_FSR,
            `BMA_OFS_PROGRAM_COUNTER_UPPER_LATCH:   region_o = BMA_RG_CORE;
            default: begin
                region_o = slot[7] ? BMA_RG_RAM : BMA_RG_NONE;
            end
        endcase
    end
endmodule

`default_nettype wire

// *** core/bma_top.sv ***
// Banked memory address decoder: fetch addressing plus banked register file.
// Assumes the core drives one data access per cycle, synchronous to clk_sys_i.
//
// What this block does
// - Thirteen-bit program counter, 8K word space
// - Fetches above 2K wrap onto implemented memory
// - Reset starts fetch at address zero
// - Taken interrupt sends fetch to address four
// - Fetch and data buses run concurrently
// - Status bits six and five pick bank for direct access
// - Each bank holds 128 byte offsets
// - Low offsets registers, upper offsets static RAM save the odd-bank gap below the shared window
// - Core registers mirrored into every bank
// - Access direct or through pointer register
`timescale 1ns/10ps
`default_nettype none
`include "bma_map.svh"

module bma_top (
    input  wire logic                        clk_sys_i,
    input  wire logic                        nrst_i,
    // Fetch side
    input  wire logic                        fetch_adv_i,
    input  wire logic                        jump_i,
    input  wire logic [`BMA_JUMP_LIT_W-1:0]  jump_lit_i,
    input  wire logic                        irq_take_i,
    // Data side
    input  wire logic                        dacc_i,
    input  wire logic                        dwr_i,
    input  wire bma_pkg::bma_ofs_t           dir_addr_i,
    input  wire logic [7:0]                  dwdata_i,
    input  wire logic                        flags_we_i,
    input  wire logic [`BMA_FLAGS_W-1:0]     flags_i,
    // Outputs
    output logic      [`BMA_PMEM_AW-1:0]     prog_addr_o,
    output logic      [`BMA_PC_W-1:0]        pc_o,
    output logic      [7:0]                  drdata_o,
    output logic                             drvalid_o,
    output logic      [7:0]                  status_o
);
    import bma_pkg::*;

    // Core registers
    logic [7:0]               status_r;   // Bank select, flags
    logic [7:0]               fsr_r;      // indirect_address_pointer
    logic [`BMA_PROGRAM_COUNTER_UPPER_LATCH_W-1:0] program_counter_upper_latch_r;   // program_counter_upper_latch
    logic [7:0]               rdata_r;    // Registered read data
    logic                     rvalid_r;   // Read data strobe

    // Static RAM, flip-flops; not reset, as real RAM powers up unknown
    logic [7:0] ram_r [0:`BMA_RAM_DEPTH-1];

    // Resolved address
    logic       use_ind;                  // Direct offset is the indirect port
    bma_bank_t  res_bank;                 // Bank after resolution
    bma_ofs_t   res_ofs;                  // Offset after resolution
    bma_region_t region;                  // Target kind
    logic [6:0] ram_idx;                  // RAM slot
    logic       wr_core;                  // Write strobe to a core register
    logic       pcl_wr;                   // Computed jump through the low byte
    logic [7:0] rd_mux;                   // Combinational read value

    // Fetch side runs beside the data path below; only low-byte writes and the upper latch reach it
    bma_pc_gen u_pc (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .adv_i       (fetch_adv_i),
        .jump_i      (jump_i),
        .jump_lit_i  (jump_lit_i),
        .irq_i       (irq_take_i),
        .pcl_wr_i    (pcl_wr),
        .pcl_data_i  (dwdata_i),
        .latch_i     (program_counter_upper_latch_r),
        .pc_o        (pc_o),
        .prog_addr_o (prog_addr_o)
    );

    // Direct offsets use the bank field; offset zero follows the pointer
    always_comb begin
        use_ind = (dir_addr_i == `BMA_OFS_INDIRECT);
        if (use_ind) begin
            // Pointer bit 7 and the IRP bit give the bank
            res_bank = {status_r[`BMA_ST_IRP], fsr_r[7]};
            res_ofs  = fsr_r[6:0];
        end else begin
            res_bank = {status_r[`BMA_ST_RP1], status_r[`BMA_ST_RP0]};
            res_ofs  = dir_addr_i;
        end
    end

    bma_data_decode u_dec (
        .bank_i    (res_bank),
        .ofs_i     (res_ofs),
        .region_o  (region),
        .ram_idx_o (ram_idx)
    );

    assign wr_core = dacc_i && dwr_i && (region == BMA_RG_CORE);
    assign pcl_wr  = wr_core && (res_ofs == `BMA_OFS_PCL);

    // Read selection; unimplemented offsets and a pointer at itself read zero
    always_comb begin
        rd_mux = 8'h00;
        case (region)
            BMA_RG_CORE: begin
                case (res_ofs)
                    `BMA_OFS_PCL:    rd_mux = pc_o[7:0];
                    `BMA_OFS_STATUS: rd_mux = status_r;
                    `BMA_OFS_FSR:    rd_mux = fsr_r;
                    `BMA_OFS_PROGRAM_COUNTER_UPPER_LATCH: rd_mux = {3'h0, program_counter_upper_latch_r};
                    default:         rd_mux = 8'h00;
                endcase
            end
            BMA_RG_RAM:  rd_mux = ram_r[ram_idx];
            BMA_RG_INDF: rd_mux = 8'h00;
            BMA_RG_NONE: rd_mux = 8'h00;
            default:     rd_mux = 8'h00;
        endcase
    end

    // Status: software writes the bank and flag bits, ALU flags win
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            status_r <= `BMA_STATUS_RST;
        end else begin
            if (wr_core && res_ofs == `BMA_OFS_STATUS) begin
                // Power bits 4 and 3 stay read-only
                status_r <= (status_r & ~`BMA_ST_WR_MASK) | (dwdata_i & `BMA_ST_WR_MASK);
            end
            if (flags_we_i) begin
                // Hardware update beats a same-cycle software write
                status_r[2:0] <= flags_i;
            end
        end
    end

    // Pointer register
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            fsr_r <= `BMA_FSR_RST;
        end else if (wr_core && res_ofs == `BMA_OFS_FSR) begin
            fsr_r <= dwdata_i;
        end
    end

    // Upper latch; only its low five bits exist
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            program_counter_upper_latch_r <= `BMA_PROGRAM_COUNTER_UPPER_LATCH_RST;
        end else if (wr_core && res_ofs == `BMA_OFS_PROGRAM_COUNTER_UPPER_LATCH) begin
            program_counter_upper_latch_r <= dwdata_i[`BMA_PROGRAM_COUNTER_UPPER_LATCH_W-1:0];
        end
    end

    // RAM write; aliasing is already folded into the index
    always_ff @(posedge clk_sys_i) begin
        if (dacc_i && dwr_i && region == BMA_RG_RAM && nrst_i) begin
            ram_r[ram_idx] <= dwdata_i;
        end
    end

    // Read data answers one cycle after the request
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rdata_r  <= `BMA_RDATA_RST;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= dacc_i && !dwr_i;
            if (dacc_i && !dwr_i) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign drdata_o  = rdata_r;
    assign drvalid_o = rvalid_r;
    assign status_o  = status_r;

    // Checks on the data side

    chk_bank_from_status: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && dir_addr_i != 7'h00) |-> (res_bank == status_o[6:5]))
        else $error("direct access used the wrong bank");

    chk_indirect_target: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && dir_addr_i == 7'h00) |-> (res_ofs == fsr_r[6:0]
            && res_bank == {status_o[7], fsr_r[7]}))
        else $error("indirect port did not follow the pointer");

    chk_low_ofs_no_ram: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (res_ofs < 7'h20) |-> (region != BMA_RG_RAM))
        else $error("low offset decoded as static RAM");

    chk_shared_top: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (res_ofs >= 7'h70) |-> (region == BMA_RG_RAM && ram_idx == res_ofs - 7'h20))
        else $error("top sixteen bytes not shared across banks");

    chk_even_bank_alias: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (res_ofs >= 7'h20 && !res_bank[0]) |-> (ram_idx == res_ofs - 7'h20))
        else $error("bank two does not alias bank zero RAM");

    chk_status_mirror: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && !dwr_i && dir_addr_i == 7'h03 && !flags_we_i)
            |=> (drvalid_o && drdata_o == $past(status_o)))
        else $error("status read through a bank gave another value");

    chk_pointer_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && dwr_i && dir_addr_i == 7'h04) |=> (fsr_r == $past(dwdata_i)))
        else $error("pointer register write lost");

    chk_fetch_with_data: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && !pcl_wr && fetch_adv_i && !jump_i && !irq_take_i)
            |=> (pc_o == $past(pc_o) + 13'h0001))
        else $error("data access stalled the fetch");

    chk_ram_readback: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && dwr_i && dir_addr_i == 7'h70)
            ##1 (dacc_i && !dwr_i && dir_addr_i == 7'h70 && status_o[5] != $past(status_o[5]))
            |=> (drdata_o == $past(dwdata_i, 2)))
        else $error("shared byte not seen from another bank");

    // Odd banks own only 32 bytes; the slots sit above the even-bank RAM
    chk_odd_bank_alias: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (res_ofs >= 7'h20 && res_ofs < 7'h40 && res_bank[0])
            |-> (region == BMA_RG_RAM && ram_idx == res_ofs + 7'h40))
        else $error("odd bank RAM slot decoded wrongly");

    // The gap between the odd-bank RAM and the shared window holds nothing
    chk_odd_bank_hole: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (res_ofs >= 7'h40 && res_ofs < 7'h70 && res_bank[0]) |-> (region == BMA_RG_NONE))
        else $error("odd bank hole decoded as storage");

    // Core registers answer from one physical copy whatever the bank
    chk_core_mirror: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (res_ofs == 7'h02 || res_ofs == 7'h03 || res_ofs == 7'h04 || res_ofs == 7'h0a)
            |-> (region == BMA_RG_CORE))
        else $error("core register not mirrored into this bank");

    // A pointer aimed at the port itself must not reach any storage
    chk_indirect_self: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (use_ind && fsr_r[6:0] == 7'h00) |-> (region == BMA_RG_INDF))
        else $error("indirect port looped onto stored location");

    // Every read request gets its strobe exactly one cycle later
    chk_read_strobe: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && !dwr_i) |=> drvalid_o)
        else $error("read request without data strobe");

    // No strobe without a read, so the core never latches stale data
    chk_no_spurious_strobe: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !(dacc_i && !dwr_i) |=> !drvalid_o)
        else $error("data strobe without read request");

    // Power bits are read-only; a software write must leave them alone
    chk_status_ro_bits: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && dwr_i && dir_addr_i == 7'h03) |=> (status_o[4:3] == $past(status_o[4:3])))
        else $error("read-only status bits changed by a write");

    // Only five latch bits exist; the write must keep exactly those
    chk_latch_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dacc_i && dwr_i && dir_addr_i == 7'h0a) |=> (program_counter_upper_latch_r == $past(dwdata_i[4:0])))
        else $error("upper latch write lost");

    // Cover points for the main scenarios
    cov_indirect_ram_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        dacc_i && !dwr_i && use_ind && region == BMA_RG_RAM);

    cov_bank3_access: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        dacc_i && res_bank == 2'b11 && region == BMA_RG_RAM);

    cov_computed_jump: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        pcl_wr ##1 fetch_adv_i);

    cov_fetch_and_write: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        fetch_adv_i && dacc_i && dwr_i);
endmodule

`default_nettype wire

// *** verif/bma_core_model.sv ***
// Core-side model: fetch strobes and one-cycle data accesses into the decoder.
// Assumes the decoder samples every request on the rising edge of clk_sys_i.
`timescale 1ns/10ps
`default_nettype none

module bma_core_model (
    input  wire logic         clk_sys_i,
    input  wire logic [7:0]   drdata_i,
    input  wire logic         drvalid_i,
    output logic              fetch_adv_o,
    output logic              jump_o,
    output logic [10:0]       jump_lit_o,
    output logic              irq_take_o,
    output logic              dacc_o,
    output logic              dwr_o,
    output bma_pkg::bma_ofs_t dir_addr_o,
    output logic [7:0]        dwdata_o,
    output logic              flags_we_o,
    output logic [2:0]        flags_o
);
    import bma_pkg::*;

    // Idle values at time zero; flag updates are not exercised by this core
    initial begin
        {fetch_adv_o, jump_o, irq_take_o, dacc_o, dwr_o, flags_we_o} = 6'h00;
        jump_lit_o = 11'h000;
        dir_addr_o = 7'h00;
        dwdata_o   = 8'h00;
        flags_o    = 3'h0;
    end

    // One fetch event: 0 step, 1 jump, 2 interrupt; held for one full cycle
    task automatic fev(input logic [1:0] k, input logic [10:0] lit);
        @(negedge clk_sys_i);
        fetch_adv_o = (k == 2'd0);
        jump_o      = (k == 2'd1);
        irq_take_o  = (k == 2'd2);
        jump_lit_o  = lit;
        @(negedge clk_sys_i);
        {fetch_adv_o, jump_o, irq_take_o} = 3'h0;
        // Released literal is scrambled so a stale value is never trusted
        jump_lit_o = ~lit;
    endtask

    // One data access, optionally with a fetch step in the same cycle
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
                       input logic adv, output logic [7:0] q, output logic v);
        @(negedge clk_sys_i);
        dacc_o      = 1'b1;
        dwr_o       = w;
        dir_addr_o  = a;
        dwdata_o    = d;
        fetch_adv_o = adv;
        @(negedge clk_sys_i);
        // Answer stands for one cycle only, so it is taken here
        q           = drdata_i;
        v           = drvalid_i;
        dacc_o      = 1'b0;
        fetch_adv_o = 1'b0;
        dir_addr_o  = ~a;
        dwdata_o    = ~d;
    endtask
endmodule

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the banked memory address decoder.
// Assumes bma_core_model drives every data and fetch input of the design.
`timescale 1ns/10ps
`default_nettype none

module tb;
    import bma_pkg::*;

    logic        clk_sys_i = 1'b0;  // 25 MHz core clock
    logic        nrst_i    = 1'b0;  // Synchronous reset, low active
    logic        adv, jmp, irq, dacc, dwr, fwe, drvalid;
    logic [10:0] lit, prog_addr;
    logic [12:0] pc;
    bma_ofs_t    addr;
    logic [7:0]  wdata, rdata, status;
    logic [2:0]  flags;
    int          n_fail      = 0;
    int          comparisons = 0;

    // Clock: invert every half period
    always #20 clk_sys_i = ~clk_sys_i;

    bma_top i_bma_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .fetch_adv_i(adv),
        .jump_i(jmp), .jump_lit_i(lit), .irq_take_i(irq), .dacc_i(dacc), .dwr_i(dwr),
        .dir_addr_i(addr), .dwdata_i(wdata), .flags_we_i(fwe), .flags_i(flags),
        .prog_addr_o(prog_addr), .pc_o(pc), .drdata_o(rdata), .drvalid_o(drvalid),
        .status_o(status));

    bma_core_model i_bma_core_model (.clk_sys_i(clk_sys_i), .drdata_i(rdata),
        .drvalid_i(drvalid), .fetch_adv_o(adv), .jump_o(jmp), .jump_lit_o(lit),
        .irq_take_o(irq), .dacc_o(dacc), .dwr_o(dwr), .dir_addr_o(addr),
        .dwdata_o(wdata), .flags_we_o(fwe), .flags_o(flags));

    // Single compare; every result is widened to 13 bits by the caller
    task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       v;
        i_bma_core_model.acc(1'b1, a, d, 1'b0, q, v);
    endtask

    // Read with optional same-cycle fetch step; checks valid pulse and data
    task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] e,
                      input logic adv = 1'b0);
        logic [7:0] q;
        logic       v;
        i_bma_core_model.acc(1'b0, a, 8'h00, adv, q, v);
        chk({nm, " valid"}, 13'h0001, {12'h000, v});
        chk(nm, {5'h00, e}, {5'h00, q});
    endtask

    // Fetch event followed by a check of both program addresses
    task automatic pcev(input string nm, input logic [1:0] k, input logic [10:0] l,
                        input logic [12:0] e);
        i_bma_core_model.fev(k, l);
        chk(nm, e, pc);
        chk({nm, " mem addr"}, {2'b00, e[10:0]}, {2'b00, prog_addr});
    endtask

    // Values every reset must leave behind
    task automatic t_reset;
        chk("pc after reset", 13'h0000, pc);
        chk("mem addr after reset", 13'h0000, {2'b00, prog_addr});
        chk("status after reset", 13'h0018, {5'h00, status});
        chk("valid after reset", 13'h0000, {12'h000, drvalid});
    endtask

    // Step, vector, jump to the top of the space, wrap, fold above 2K
    task automatic t_fetch;
        pcev("step", 2'd0, 11'h000, 13'h0001);
        pcev("irq vector", 2'd2, 11'h000, 13'h0004);
        wr(7'h0a, 8'h18);
        pcev("jump top", 2'd1, 11'h7ff, 13'h1fff);
        pcev("wrap", 2'd0, 11'h000, 13'h0000);
        wr(7'h0a, 8'h08);
        pcev("jump above 2k", 2'd1, 11'h001, 13'h0801);
        wr(7'h0a, 8'h00);
        wr(7'h02, 8'h40);
        chk("computed jump", 13'h0040, pc);
        // Data read of the low byte while the fetch side steps
        rd("pc low read", 7'h02, 8'h40, 1'b1);
        chk("pc during read", 13'h0041, pc);
    endtask

    // Bank select, RAM windows, aliases, mirrored core registers
    task automatic t_banks;
        wr(7'h03, 8'h00);
        wr(7'h20, 8'ha0);
        wr(7'h25, 8'h5a);
        wr(7'h7f, 8'h7e);
        wr(7'h03, 8'h20);
        wr(7'h20, 8'hb1);
        wr(7'h25, 8'hc3);
        wr(7'h75, 8'h33);
        wr(7'h40, 8'hff);
        wr(7'h04, 8'h3c);
        rd("bank1 hole", 7'h40, 8'h00);
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, {1'b0, b[1:0], 5'h00});
            chk("bank bits", {11'h000, b[1:0]}, {11'h000, status[6:5]});
            rd("gpr 20", 7'h20, b[0] ? 8'hb1 : 8'ha0);
            rd("shared 75", 7'h75, 8'h33);
            rd("mirror ptr", 7'h04, 8'h3c);
            rd("mirror status", 7'h03, {1'b0, b[1:0], 5'h18});
        end
        wr(7'h03, 8'h00);
        rd("top offset", 7'h7f, 8'h7e);
    endtask

    // Offset zero follows the pointer, whatever bank is selected
    task automatic t_indirect;
        wr(7'h03, 8'h60);
        wr(7'h04, 8'h25);
        rd("ind bank0", 7'h00, 8'h5a);
        wr(7'h04, 8'ha5);
        rd("ind bank1", 7'h00, 8'hc3);
        wr(7'h00, 8'h77);
        wr(7'h03, 8'h20);
        rd("ind write landed", 7'h25, 8'h77);
    endtask

    // Main sequence, with a second reset after the last test
    initial begin
        repeat (6) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        t_reset();
        t_fetch();
        t_banks();
        t_indirect();
        @(negedge clk_sys_i);
        nrst_i = 1'b0;
        @(negedge clk_sys_i);
        nrst_i = 1'b1;
        t_reset();
        report_and_stop();
    end

    // Watchdog: the sequence needs well under 400 cycles
    initial begin
        #(40 * 3000);
        n_fail++;
        report_and_stop();
    end
endmodule

`default_nettype wire
